/* hw/lcdfc_pkg.sv */
package lcdfc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_PIN_EN = 4'h2;
    localparam logic [3:0] ADDR_BP_ROLE = 4'h3;
    localparam logic [3:0] ADDR_SUPPLY = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int C0_EN_BIT = 7;
    localparam int C0_SRC_BIT = 6;
    localparam int C0_PRE_LSB = 3;
    localparam int C0_DUTY_LSB = 0;
    localparam int C1_IEN_BIT = 7;
    localparam int C1_FULL_BIT = 2;
    localparam int C1_WAIT_BIT = 1;
    localparam int C1_STOP_BIT = 0;
    localparam int SUP_BIAS_REGULATOR_ENABLE_BIT = 2;
    localparam int SUP_SEL_LSB = 0;
    localparam logic [7:0] CTRL0_RESET = 8'h03;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [1:0] SUPPLY_EXT_TOP = 2'h3;
    localparam int NUM_PINS = 29;
    localparam int PRE_BASE = 4;
    localparam int DIV_EIGHT = 8;
    localparam int DIV_W = 16;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 10000000;
    localparam real PANEL_CLK_MAX_KHZ = 39.063;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } lcdfc_req_t;

    typedef enum logic [1:0] {
        LCDFC_OFF = 2'b00,
        LCDFC_RUN = 2'b01,
        LCDFC_HALT = 2'b10
    } lcdfc_state_t;

endpackage

/* hw/lcdfc_core.sv */
// Function
// - Disabled: pins off, clocks stopped, rail tied.
// - Enabled: enabled pins drive, bias on.
// - Control0 bit6 selects panel clock source.
// - Frame divide (duty+1)*8*(4+prescaler)*Y.
// - Y is 2,2,3,3,4,5,8,16 by duty.
// - Duty field selects one to eight backplanes.
// - Duty resets to four backplanes.
// - Control1 bit7 enables frame-start interrupt.
// - Full drive with supply 11, no regulator.
// - Otherwise shared GPIO open-drain, main supply.
// - Control1 bit1 halts driver in wait.
// - Control1 bit0 halts driver in stop.
// - Running frame interrupt wakes from low power.
// - Pin drives only when enabled; role bit.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lcdfc_core
    import lcdfc_pkg::*;
#(
    parameter int PINS = NUM_PINS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ext_ref_clock,
    input wire logic alt_clock,
    input wire logic in_wait,
    input wire logic in_stop,
    input wire lcdfc_req_t req,
    output logic [31:0] rdata,
    output logic irq,
    output logic wake,
    output logic panel_clock,
    output logic frame_start,
    output logic [2:0] bp_phase,
    output logic [PINS-1:0] pin_wave_en,
    output logic [PINS-1:0] pin_is_bp,
    output logic bias_on,
    output logic top_rail_tied,
    output logic gpio_push_pull
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl0, next_ctrl0;
    logic [7:0] ctrl1, next_ctrl1;
    logic [PINS-1:0] pin_enable_bits, next_pin_enable_bits;
    logic [PINS-1:0] backplane_role_bits, next_backplane_role_bits;
    logic [2:0] supply, next_supply;
    logic stat, next_stat;
    logic mask, next_mask;
    logic [31:0] next_rdata;
    logic driver_enable_bit, running;
    logic [2:0] duty, frame_prescaler;
    logic [4:0] y_fac;
    logic [DIV_W-1:0] cnt, next_cnt, div_len;
    logic [2:0] next_bp_phase;
    logic ps_sync, ps_prev, next_ps_prev, ps_rise;
    lcdfc_state_t state, next_state;

    assign driver_enable_bit = ctrl0[C0_EN_BIT];
    assign duty = ctrl0[C0_DUTY_LSB +: 3];
    assign frame_prescaler = ctrl0[C0_PRE_LSB +: 3];

    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_pin_enable_bits = pin_enable_bits;
        next_backplane_role_bits = backplane_role_bits;
        next_supply = supply;
        next_mask = mask;
        next_stat = stat;
        next_rdata = 32'h0;
        if (req.wr) begin
            unique case (req.addr)
                // Source, prescaler and duty are trusted to stay put while enabled.
                ADDR_CTRL0: next_ctrl0 = req.wdata[7:0];
                ADDR_CTRL1: next_ctrl1 = req.wdata[7:0] & 8'h87;
                ADDR_PIN_EN: next_pin_enable_bits = req.wdata[PINS-1:0];
                ADDR_BP_ROLE: next_backplane_role_bits = req.wdata[PINS-1:0];
                ADDR_SUPPLY: next_supply = req.wdata[2:0];
                ADDR_IRQ_STAT: next_stat = stat & ~req.wdata[0];
                ADDR_IRQ_MASK: next_mask = req.wdata[0];
                default: ;
            endcase
        end
        // Set beats clear so no frame start is lost.
        if (frame_start && ctrl1[C1_IEN_BIT]) begin
            next_stat = 1'b1;
        end
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CTRL0: next_rdata = {24'h0, ctrl0};
                ADDR_CTRL1: next_rdata = {24'h0, ctrl1};
                ADDR_PIN_EN: next_rdata = 32'(pin_enable_bits);
                ADDR_BP_ROLE: next_rdata = 32'(backplane_role_bits);
                ADDR_SUPPLY: next_rdata = {29'h0, supply};
                ADDR_IRQ_STAT: next_rdata = {31'h0, stat};
                ADDR_IRQ_MASK: next_rdata = {31'h0, mask};
                ADDR_STATUS: next_rdata = {27'h0, bp_phase, state};
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl0 <= CTRL0_RESET;
            ctrl1 <= CTRL1_RESET;
            pin_enable_bits <= '0;
            backplane_role_bits <= '0;
            supply <= 3'h0;
            stat <= 1'b0;
            mask <= 1'b0;
            rdata <= 32'h0;
        end else begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            pin_enable_bits <= next_pin_enable_bits;
            backplane_role_bits <= next_backplane_role_bits;
            supply <= next_supply;
            stat <= next_stat;
            mask <= next_mask;
            rdata <= next_rdata;
        end
    end

    assign irq = stat & mask;
    // Only a running driver makes frame starts, but the flag is sticky, so irq can stay high after the driver halts or turns off.
    assign wake = irq & (in_wait | in_stop);

    // ----------------------------------------
    // Operating state
    // ----------------------------------------
    always_comb begin
        next_state = state;
        if (!driver_enable_bit) begin
            next_state = LCDFC_OFF;
        end else if ((in_wait && ctrl1[C1_WAIT_BIT]) || (in_stop && ctrl1[C1_STOP_BIT])) begin
            next_state = LCDFC_HALT;
        end else begin
            next_state = LCDFC_RUN;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LCDFC_OFF;
        end else begin
            state <= next_state;
        end
    end

    assign running = (state == LCDFC_RUN);

    // ----------------------------------------
    // Panel clock and frame divider
    // ----------------------------------------
    // The panel clock is sampled as a level; it is far slower than clk.
    assign panel_clock = ctrl0[C0_SRC_BIT] ? alt_clock : ext_ref_clock;
    assign ps_sync = panel_clock;
    assign ps_rise = ps_sync & ~ps_prev;

    always_comb begin
        unique case (duty)
            3'h0: y_fac = 5'h02;
            3'h1: y_fac = 5'h02;
            3'h2: y_fac = 5'h03;
            3'h3: y_fac = 5'h03;
            3'h4: y_fac = 5'h04;
            3'h5: y_fac = 5'h05;
            3'h6: y_fac = 5'h08;
            3'h7: y_fac = 5'h10;
        endcase
        div_len = DIV_W'((32'(duty) + 1) * DIV_EIGHT * (PRE_BASE + 32'(frame_prescaler))
            * 32'(y_fac));
    end

    always_comb begin
        next_cnt = cnt;
        next_bp_phase = bp_phase;
        next_ps_prev = ps_sync;
        frame_start = 1'b0;
        if (!running) begin
            next_cnt = '0; // Divider clocks stopped while off or halted.
            if (state == LCDFC_OFF) begin
                next_bp_phase = 3'h0;
            end
        end else if (ps_rise) begin
            if (cnt >= div_len - 1'b1) begin
                next_cnt = '0;
                frame_start = 1'b1;
                next_bp_phase = (bp_phase >= duty) ? 3'h0 : bp_phase + 3'h1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
            bp_phase <= 3'h0;
            ps_prev <= 1'b0;
        end else begin
            cnt <= next_cnt;
            bp_phase <= next_bp_phase;
            ps_prev <= next_ps_prev;
        end
    end

    // ----------------------------------------
    // Pins and supplies
    // ----------------------------------------
    assign pin_wave_en = running ? pin_enable_bits : '0;
    assign pin_is_bp = backplane_role_bits;
    assign bias_on = running;
    assign top_rail_tied = ~driver_enable_bit;
    assign gpio_push_pull = ctrl1[C1_FULL_BIT] && supply[SUP_SEL_LSB +: 2] == SUPPLY_EXT_TOP
        && !supply[SUP_BIAS_REGULATOR_ENABLE_BIT];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Multi-step behaviours are named as sequences so the properties read as cause and effect.
    sequence s_frame_event;
        frame_start && ctrl1[C1_IEN_BIT];
    endsequence
    sequence s_enable_rise;
        !driver_enable_bit ##1 driver_enable_bit && !in_wait && !in_stop;
    endsequence

    AST_OFF_QUIET: assert property (@(posedge clk) disable iff (rst)
        !driver_enable_bit |=> (pin_wave_en == '0) && !bias_on)
        else $error("driver active while disabled");
    AST_NO_FRAME_OFF: assert property (@(posedge clk) disable iff (rst)
        !running |-> !frame_start)
        else $error("frame start while divider stopped");
    AST_RUN_PINS: assert property (@(posedge clk) disable iff (rst)
        running |-> pin_wave_en == pin_enable_bits && bias_on)
        else $error("running pins do not follow enables");
    AST_RUN_ON_ENABLE: assert property (@(posedge clk) disable iff (rst)
        s_enable_rise |=> running)
        else $error("driver did not start after enable");
    AST_SRC: assert property (@(posedge clk) disable iff (rst)
        ctrl0[C0_SRC_BIT] |-> panel_clock == alt_clock)
        else $error("wrong panel clock source");
    AST_SRC_EXT: assert property (@(posedge clk) disable iff (rst)
        !ctrl0[C0_SRC_BIT] |-> panel_clock == ext_ref_clock)
        else $error("external reference not selected");
    AST_DIV: assert property (@(posedge clk) disable iff (rst)
        frame_start |-> $past(cnt) == div_len - 1'b1 || cnt == div_len - 1'b1)
        else $error("frame start at wrong count");
    AST_CNT_BOUND: assert property (@(posedge clk) disable iff (rst)
        running && driver_enable_bit |-> cnt < div_len)
        else $error("divider count beyond frame length");
    AST_Y8: assert property (@(posedge clk) disable iff (rst)
        duty == 3'h7 |-> y_fac == 5'h10)
        else $error("wrong Y for eight backplanes");
    AST_PHASE: assert property (@(posedge clk) disable iff (rst)
        bp_phase <= duty || $changed(duty))
        else $error("backplane phase beyond duty");
    AST_PHASE_WRAP: assert property (@(posedge clk) disable iff (rst)
        frame_start && bp_phase == duty |=> bp_phase == 3'h0)
        else $error("backplane phase did not wrap");
    AST_DUTY_RESET: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> ctrl0 == CTRL0_RESET)
        else $error("control reset value wrong");
    AST_IRQ_SET: assert property (@(posedge clk) disable iff (rst)
        s_frame_event |=> stat)
        else $error("frame start did not set flag");
    AST_NO_IRQ: assert property (@(posedge clk) disable iff (rst)
        !stat && !(frame_start && ctrl1[C1_IEN_BIT]) |=> !stat)
        else $error("flag set without frame event");
    AST_STAT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        stat && req.wr && req.addr == ADDR_IRQ_STAT && req.wdata[0]
        && !(frame_start && ctrl1[C1_IEN_BIT]) |=> !stat)
        else $error("write one did not clear flag");
    AST_FULL: assert property (@(posedge clk) disable iff (rst)
        !ctrl1[C1_FULL_BIT] |-> !gpio_push_pull)
        else $error("push-pull without full drive");
    AST_WAIT: assert property (@(posedge clk) disable iff (rst)
        driver_enable_bit && in_wait && ctrl1[C1_WAIT_BIT] |=> !running)
        else $error("driver runs in wait");
    AST_STOP: assert property (@(posedge clk) disable iff (rst)
        driver_enable_bit && in_stop && ctrl1[C1_STOP_BIT] |=> !running)
        else $error("driver runs in stop");
    AST_HALT_PHASE: assert property (@(posedge clk) disable iff (rst)
        state == LCDFC_HALT |=> $stable(bp_phase))
        else $error("backplane phase moved while halted");
    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        irq && in_stop |-> wake)
        else $error("no wake on frame interrupt");
    AST_PHASE_STEP: assert property (@(posedge clk) disable iff (rst)
        frame_start && bp_phase < duty |=> bp_phase == $past(bp_phase) + 3'h1)
        else $error("backplane phase did not advance");

endmodule
`default_nettype wire

/* testbench/lcdfc_glass.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Glass model: times frames, flags stray drive
// ----------------------------------------
module lcdfc_glass
    import lcdfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic frame_start,
    input wire logic bias_on,
    input wire logic [NUM_PINS-1:0] pin_wave_en,
    output int frames,
    output int gap,
    output logic fault
);
    int cnt;
    // The first gap also counts the time from reset to enable, so only later gaps are meaningful.
    always @(posedge clk) begin
        if (rst) begin
            frames <= 0;
            gap <= 0;
            cnt <= 0;
            fault <= 1'b0;
        end else begin
            cnt <= cnt + 1;
            if (frame_start) begin
                frames <= frames + 1;
                gap <= cnt + 1;
                cnt <= 0;
            end
            if (|pin_wave_en && !bias_on) begin
                fault <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/lcd_frame_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_control_tb_top;
    import lcdfc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_ref_clock = 1'b0;
    logic alt_clock = 1'b0;
    logic in_wait = 1'b0;
    logic in_stop = 1'b0;
    lcdfc_req_t req = '0;
    logic [31:0] rdata;
    logic irq, wake, panel_clock, frame_start, bias_on, top_rail_tied, gpio_push_pull, fault;
    logic [2:0] bp_phase;
    logic [NUM_PINS-1:0] pin_wave_en, pin_is_bp;
    logic [7:0] ext_div = '0;
    logic [7:0] alt_div = '0;
    logic [4:0] gp [4] = '{5'h17, 5'h14, 5'h1e, 5'h06};
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int frames, gap;

    lcdfc_core i_dut (.clk(clk), .rst(rst), .ext_ref_clock(ext_ref_clock),
        .alt_clock(alt_clock), .in_wait(in_wait), .in_stop(in_stop), .req(req),
        .rdata(rdata), .irq(irq), .wake(wake), .panel_clock(panel_clock),
        .frame_start(frame_start), .bp_phase(bp_phase), .pin_wave_en(pin_wave_en),
        .pin_is_bp(pin_is_bp), .bias_on(bias_on), .top_rail_tied(top_rail_tied),
        .gpio_push_pull(gpio_push_pull));
    lcdfc_glass i_glass (.clk(clk), .rst(rst), .frame_start(frame_start), .bias_on(bias_on),
        .pin_wave_en(pin_wave_en), .frames(frames), .gap(gap), .fault(fault));

    // ----------------------------------------
    // Clocks: panel sources kept inside the legal band
    // ----------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        ext_div <= (ext_div == 8'h7f) ? 8'h00 : ext_div + 8'h01;
        alt_div <= (alt_div == 8'h95) ? 8'h00 : alt_div + 8'h01;
        if (ext_div == 8'h7f) ext_ref_clock <= !ext_ref_clock;
        if (alt_div == 8'h95) alt_clock <= !alt_clock;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        req <= '0;
        #1;
        check_val(rdata, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic count_rises(input int win, input int exp);
        int n;
        logic prev;
        n = 0;
        prev = panel_clock;
        repeat (win) begin
            @(posedge clk);
            #1;
            if (panel_clock && !prev) n++;
            prev = panel_clock;
        end
        check_val(32'(n), 32'(exp));
    endtask
    task automatic wait_frame();
        int target;
        target = frames + 1;
        for (int i = 0; i < 34000 && frames < target; i++) begin
            @(posedge clk);
            #1;
        end
        check_val(32'(frames >= target), 32'h1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_val({top_rail_tied, bias_on, irq, 29'(pin_wave_en)}, 32'h8000_0000);
        rd_chk(ADDR_CTRL0, 32'h03);
        wr_reg(4'h8, 32'hff);
        rd_chk(4'h8, 32'h0);
        wr_reg(ADDR_CTRL1, 32'hff);
        rd_chk(ADDR_CTRL1, 32'h87);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CTRL1, 32'(gp[i][4]) << C1_FULL_BIT);
            wr_reg(ADDR_SUPPLY, 32'(gp[i][3:1]));
            settle();
            check_val(32'(gpio_push_pull), 32'(gp[i][0]));
        end
        wr_reg(ADDR_CTRL1, 32'h0);
        wr_reg(ADDR_PIN_EN, 32'h1234_5678);
        wr_reg(ADDR_BP_ROLE, 32'h0000_00ff);
        // Source, prescaler and duty only ever change with the driver off.
        wr_reg(ADDR_CTRL0, 32'h41);
        wr_reg(ADDR_CTRL0, 32'hc1);
        settle();
        check_val({bias_on, top_rail_tied, 1'b0, 29'(pin_wave_en)}, 32'h9234_5678);
        check_val(32'(pin_is_bp), 32'hff);
        count_rises(3000, 10);
        wr_reg(ADDR_CTRL0, 32'h41);
        wr_reg(ADDR_CTRL0, 32'h01);
        wr_reg(ADDR_CTRL0, 32'h81);
        rd_chk(ADDR_CTRL0, 32'h81);
        settle();
        count_rises(2560, 10);
        wait_frame();
        check_val(32'(bp_phase), 32'h1);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        wr_reg(ADDR_CTRL1, 32'h80);
        wait_frame();
        check_val(32'(gap), 32'h0000_8000);
        check_val({29'h0, bp_phase}, 32'h0);
        check_val(32'(irq), 32'h0);
        wr_reg(ADDR_IRQ_MASK, 32'h1);
        settle();
        check_val(32'(irq), 32'h1);
        rd_chk(ADDR_IRQ_STAT, 32'h1);
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            in_wait <= (m == 0);
            in_stop <= (m == 1);
            settle();
            check_val({30'h0, bias_on, wake}, 32'h3);
            wr_reg(ADDR_CTRL1, (m == 0) ? 32'h82 : 32'h81);
            settle();
            check_val({bias_on, 2'h0, 29'(pin_wave_en)}, 32'h0);
            @(posedge clk);
            in_wait <= 1'b0;
            in_stop <= 1'b0;
            wr_reg(ADDR_CTRL1, 32'h80);
            settle();
            check_val(32'(bias_on), 32'h1);
        end
        wr_reg(ADDR_IRQ_STAT, 32'h1);
        settle();
        check_val(32'(irq), 32'h0);
        wr_reg(ADDR_CTRL0, 32'h01);
        settle();
        check_val({top_rail_tied, bias_on, 1'b0, 29'(pin_wave_en)}, 32'h8000_0000);
        check_val(32'(fault), 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
